//--- i2c_master_model.sv
// behavioural two-wire bus master, the far side of the slave port
// assumes the bench resolves both lines with pull-ups; drives on falling CLK
`timescale 1ns/1ps

module i2c_master_model
(
  input wire logic clk,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  // half period of SCL in CLK cycles
  localparam int HP = 80;

  initial
  begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // also serves as repeated start from SCL low
  task automatic start;
    sda_oe <= 1'h0;
    wt(HP / 2);
    scl_oe <= 1'h0;
    wt(HP);
    sda_oe <= 1'h1;
    wt(HP);
    scl_oe <= 1'h1;
  endtask : start

  task automatic stop;
    wt(HP / 2);
    sda_oe <= 1'h1;
    wt(HP / 2);
    scl_oe <= 1'h0;
    wt(HP);
    sda_oe <= 1'h0;
    wt(HP);
  endtask : stop

  // sda set mid low phase, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    wt(HP / 2);
    sda_oe <= ~b;
    wt(HP / 2);
    scl_oe <= 1'h0;
    wt(HP);
    r = sda;
    scl_oe <= 1'h1;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'h1, r);
      b[i] = r;
    end
    bit_io(~more, r);
  endtask : rd_byte
endmodule : i2c_master_model

//--- pmic_i2c_pkg.sv
// package for the two-wire slave port: addresses, codes, states and state records
// assumes a link oversampling clock and a core clock, both reset by one active-low reset
package pmic_i2c_pkg;

  // ---------------------------------------------------------------
  // bus constants
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MAIN_HI = 7'h48;
  localparam logic [6:0] ADDR_MAIN_LO = 7'h40;
  localparam logic [6:0] ADDR_TEST = 7'h49;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    L_IDLE, L_ADDR, L_ADDR_ACK, L_PTR, L_PTR_ACK, L_WDATA, L_WDATA_ACK, L_RDATA, L_RDATA_ACK
  } link_state_t;

  typedef enum logic {C_IDLE, C_READ} core_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic sel_m;
    logic sel_s;
    logic ack_m;
    logic ack_s;
    logic ack_d;
    link_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] rd_buf;
    reg_req_t req;
    logic req_tgl;
    logic sda_oe;
    logic hs;
    logic test;
    logic pin_lo;
  } link_t;

  typedef struct packed {
    logic rq_m;
    logic rq_s;
    logic rq_d;
    core_state_t st;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic [7:0] rsp;
    logic ack_tgl;
  } core_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam link_t LINK_RST = '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
    sda_d: 1'b1, st: L_IDLE, default: '0};
  localparam core_t CORE_RST = '{st: C_IDLE, default: '0};

endpackage : pmic_i2c_pkg

//--- pmic_i2c_slave_port.sv
// two-wire slave port: serial engine on LINK_CLK, register access strobes on CLK
// assumes an open-drain bus resolved outside, and a register bank on CLK that answers
// RD_DATA combinationally for REG_ADDR
//
// Summary of operation
// - answer address 0x48 with select high, 0x40 with select low, 0x49 for test.
// - other addresses get no acknowledge; SDA stays released.
// - registers are 8 bits; first byte after write address sets the 8-bit pointer.
// - pointer steps by one after every written or read data byte.
// - one bit per SCL cycle; SDA changes while SCL high are conditions.
// - packets are eight data bits, MSB first, plus one acknowledge bit.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - both lines are left released while no transfer is running.
// - repeated START behaves exactly like START and restarts address reception.
// - after STOP or a missed address, SCL is ignored until next START.
// - acknowledge drives SDA low before ninth rise and through its high phase.
// - not-acknowledge leaves SDA released across the ninth clock.
// - every pointer value is acknowledged, whether or not a register exists.
// - SCL is never held low; no clock stretching.
// - general call address is not acknowledged and its transfer ignored.
// - the device ID query is not implemented and gets no answer.
// - the master makes every SCL pulse; this port only acts as slave.
// - works from static SCL up to the top rate; no timeouts.
// - rates up to 1MHz need no speed-change sequence.
// - pointer survives interface supply cycling; only the device reset clears it.
// - START plus master code 0000_1xxx gets no acknowledge and enables high-speed mode.
// - STOP leaves high-speed mode; repeated START keeps the current mode.
// - STOP does not change the register pointer.
// - read: pointer write, repeated START with read bit, bytes from pointed register.
`timescale 1ns/1ps

module pmic_i2c_slave_port
  import pmic_i2c_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic LINK_CLK,
  input wire logic ADDR_SEL,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic HS_MODE,
  output logic TEST_SEL,
  output logic [7:0] REG_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_STB,
  input wire logic [7:0] RD_DATA
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [6:0] a, input logic sel);
    addr_hit = (a == (sel ? ADDR_MAIN_HI : ADDR_MAIN_LO)) || (a == ADDR_TEST);
  endfunction : addr_hit

  function automatic reg_req_t mk_req(input logic we, input logic [7:0] a, input logic [7:0] d);
    mk_req = '{we: we, addr: a, data: d};
  endfunction : mk_req

  // starts a read byte: first bit driven now, prefetch of the following register
  function automatic link_t load_byte(input link_t x);
    link_t y;
    y = x;
    y.st = L_RDATA;
    y.cnt = 4'h0;
    y.sh = x.rd_buf;
    y.sda_oe = ~x.rd_buf[7];
    y.ptr = x.ptr + PTR_STEP;
    y.req = mk_req(1'b0, y.ptr, 8'h00);
    y.req_tgl = ~x.req_tgl;
    load_byte = y;
  endfunction : load_byte

  link_t l;
  link_t next_l;
  core_t c;
  core_t next_c;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic rx_state;

  // ---------------------------------------------------------------
  // bus conditions
  // ---------------------------------------------------------------
  assign start = l.scl_s & l.scl_d & l.sda_d & ~l.sda_s;
  assign stop = l.scl_s & l.scl_d & ~l.sda_d & l.sda_s;
  assign rise = l.scl_s & ~l.scl_d;
  assign fall = ~l.scl_s & l.scl_d;
  assign rx_state = (l.st == L_ADDR) || (l.st == L_PTR) || (l.st == L_WDATA);

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  always_comb
  begin
    next_l = l;
    next_l.scl_m = SCL_I;
    next_l.scl_s = l.scl_m;
    next_l.scl_d = l.scl_s;
    next_l.sda_m = SDA_I;
    next_l.sda_s = l.sda_m;
    next_l.sda_d = l.sda_s;
    next_l.sel_m = ADDR_SEL;
    next_l.sel_s = l.sel_m;
    next_l.ack_m = c.ack_tgl;
    next_l.ack_s = l.ack_m;
    next_l.ack_d = l.ack_s;
    next_l.pin_lo = 1'b0;
    // response data is held stable by the core until its toggle is seen
    if (l.ack_s != l.ack_d)
    begin
      next_l.rd_buf = c.rsp;
    end
    if (rx_state && rise && (l.cnt < BYTE_BITS))
    begin
      next_l.sh = {l.sh[6:0], l.sda_s};
      next_l.cnt = l.cnt + 4'h1;
    end
    if (stop)
    begin
      next_l.st = L_IDLE;
      next_l.sda_oe = 1'b0;
      next_l.hs = 1'b0;
      next_l.test = 1'b0;
    end
    else if (start)
    begin
      next_l.st = L_ADDR;
      next_l.cnt = 4'h0;
      next_l.sda_oe = 1'b0;
    end
    else
    begin
      case (l.st)
        L_IDLE:
        begin
          // no timeout anywhere: the engine waits on SCL for as long as it takes
          next_l.sda_oe = 1'b0;
        end
        L_ADDR:
        begin
          if (fall && (l.cnt == BYTE_BITS))
          begin
            if (l.sh[7:3] == HS_CODE)
            begin
              next_l.hs = 1'b1;
              next_l.st = L_IDLE;
            end
            else if (addr_hit(l.sh[7:1], l.sel_s))
            begin
              next_l.sda_oe = 1'b1;
              next_l.rw = l.sh[0];
              next_l.test = (l.sh[7:1] == ADDR_TEST);
              next_l.st = L_ADDR_ACK;
              if (l.sh[0])
              begin
                next_l.req = mk_req(1'b0, l.ptr, 8'h00);
                next_l.req_tgl = ~l.req_tgl;
              end
            end
            else
            begin
              next_l.st = L_IDLE;
            end
          end
        end
        L_ADDR_ACK:
        begin
          if (fall)
          begin
            if (l.rw)
            begin
              next_l = load_byte(next_l);
            end
            else
            begin
              next_l.sda_oe = 1'b0;
              next_l.cnt = 4'h0;
              next_l.st = L_PTR;
            end
          end
        end
        L_PTR:
        begin
          if (fall && (l.cnt == BYTE_BITS))
          begin
            next_l.ptr = l.sh;
            next_l.sda_oe = 1'b1;
            next_l.st = L_PTR_ACK;
          end
        end
        L_PTR_ACK, L_WDATA_ACK:
        begin
          if (fall)
          begin
            next_l.sda_oe = 1'b0;
            next_l.cnt = 4'h0;
            next_l.st = L_WDATA;
          end
        end
        L_WDATA:
        begin
          if (fall && (l.cnt == BYTE_BITS))
          begin
            next_l.req = mk_req(1'b1, l.ptr, l.sh);
            next_l.req_tgl = ~l.req_tgl;
            next_l.ptr = l.ptr + PTR_STEP;
            next_l.sda_oe = 1'b1;
            next_l.st = L_WDATA_ACK;
          end
        end
        L_RDATA:
        begin
          if (rise && (l.cnt < BYTE_BITS))
          begin
            next_l.cnt = l.cnt + 4'h1;
          end
          else if (fall && (l.cnt == BYTE_BITS))
          begin
            next_l.sda_oe = 1'b0;
            next_l.st = L_RDATA_ACK;
          end
          else if (fall && (l.cnt != 4'h0))
          begin
            next_l.sh = {l.sh[6:0], 1'b0};
            next_l.sda_oe = ~l.sh[6];
          end
        end
        L_RDATA_ACK:
        begin
          if (rise && l.sda_s)
          begin
            next_l.st = L_IDLE;
          end
          else if (fall)
          begin
            next_l = load_byte(next_l);
          end
        end
        default:
        begin
          next_l.st = L_IDLE;
          next_l.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // pointer lives here, cleared only by the device reset
  always_ff @(posedge LINK_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      l <= LINK_RST;
    end
    else
    begin
      l <= next_l;
    end
  end

  // ---------------------------------------------------------------
  // core domain
  // ---------------------------------------------------------------
  always_comb
  begin
    next_c = c;
    next_c.rq_m = l.req_tgl;
    next_c.rq_s = c.rq_m;
    next_c.rq_d = c.rq_s;
    next_c.wr_stb = 1'b0;
    case (c.st)
      C_IDLE:
      begin
        if (c.rq_s != c.rq_d)
        begin
          next_c.addr = l.req.addr;
          if (l.req.we)
          begin
            next_c.wdata = l.req.data;
            next_c.wr_stb = 1'b1;
            next_c.ack_tgl = ~c.ack_tgl;
          end
          else
          begin
            next_c.st = C_READ;
          end
        end
      end
      C_READ:
      begin
        next_c.rsp = RD_DATA;
        next_c.ack_tgl = ~c.ack_tgl;
        next_c.st = C_IDLE;
      end
      default:
      begin
        next_c.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      c <= CORE_RST;
    end
    else
    begin
      c <= next_c;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SCL_O = l.pin_lo;
  assign SCL_OE = l.pin_lo;
  assign SDA_O = l.pin_lo;
  assign SDA_OE = l.sda_oe;
  assign HS_MODE = l.hs;
  assign TEST_SEL = l.test;
  assign REG_ADDR = c.addr;
  assign WR_DATA = c.wdata;
  assign WR_STB = c.wr_stb;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_scl_released: assert property (@(posedge LINK_CLK) disable iff (!RSTN) !SCL_OE)
    else $error("scl driven by slave");

  chk_idle_release: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_IDLE) |-> !SDA_OE)
    else $error("sda driven while idle");

  chk_start_restart: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    start |=> (l.st == L_ADDR) && (l.cnt == 4'h0) && !SDA_OE && (HS_MODE == $past(HS_MODE)))
    else $error("start did not restart address");

  chk_stop_mode: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    stop |=> (l.st == L_IDLE) && !HS_MODE && (l.ptr == $past(l.ptr)))
    else $error("stop handling wrong");

  chk_addr_match: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_ADDR) && fall && (l.cnt == BYTE_BITS) && addr_hit(l.sh[7:1], l.sel_s)
    && (l.sh[7:3] != HS_CODE) |=> SDA_OE && (l.st == L_ADDR_ACK))
    else $error("own address not acknowledged");

  chk_addr_miss: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_ADDR) && fall && (l.cnt == BYTE_BITS) && !addr_hit(l.sh[7:1], l.sel_s)
    |=> !SDA_OE && (l.st == L_IDLE))
    else $error("foreign address acknowledged");

  chk_hs_entry: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_ADDR) && fall && (l.cnt == BYTE_BITS) && (l.sh[7:3] == HS_CODE)
    |=> HS_MODE && !SDA_OE)
    else $error("master code not handled");

  chk_ptr_ack: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_PTR) && fall && (l.cnt == BYTE_BITS) |=> SDA_OE && (l.ptr == $past(l.sh)))
    else $error("pointer byte not taken");

  chk_wr_incr: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (l.st == L_WDATA) && fall && (l.cnt == BYTE_BITS)
    |=> (l.ptr == 8'($past(l.ptr) + PTR_STEP)) && l.req.we)
    else $error("pointer not advanced after write");

  chk_core_write: assert property (@(posedge CLK) disable iff (!RSTN)
    (c.st == C_IDLE) && (c.rq_s != c.rq_d) && l.req.we |=> WR_STB ##1 !WR_STB)
    else $error("write strobe missing");

endmodule : pmic_i2c_slave_port

//--- tb_top.sv
// self-checking bench for the two-wire slave port
// assumes the master model above and a 256-byte register bank kept here
`timescale 1ns/1ps

module tb_top;
  import pmic_i2c_pkg::*;

  typedef struct packed {logic sel; logic [6:0] a; logic ack;} row_t;

  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic rstn = 1'h0;
  logic addr_sel = 1'h1;
  logic m_scl_oe, m_sda_oe, scl_o, scl_oe, sda_o, sda_oe, hs, tsel, wr_stb, a;
  logic [7:0] reg_addr, wr_data, b;
  logic [7:0] mem [256];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  wire scl = ~(m_scl_oe | (scl_oe & ~scl_o));
  wire sda = ~(m_sda_oe | (sda_oe & ~sda_o));
  wire [7:0] rd_data = mem[reg_addr];
  row_t rows [8] = '{'{1'h1, ADDR_MAIN_HI, 1'h1}, '{1'h1, ADDR_MAIN_LO, 1'h0},
    '{1'h0, ADDR_MAIN_LO, 1'h1}, '{1'h0, ADDR_MAIN_HI, 1'h0}, '{1'h1, ADDR_TEST, 1'h1},
    '{1'h0, ADDR_TEST, 1'h1}, '{1'h1, 7'h00, 1'h0}, '{1'h1, 7'h7c, 1'h0}};

  always #10 clk = ~clk;
  initial
  begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  always @(posedge clk) if (wr_stb) mem[reg_addr] <= wr_data;

  pmic_i2c_slave_port DUT (.CLK(clk), .RSTN(rstn), .LINK_CLK(link_clk), .ADDR_SEL(addr_sel),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .HS_MODE(hs), .TEST_SEL(tsel), .REG_ADDR(reg_addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_DATA(rd_data));

  i2c_master_model M (.clk(clk), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // write one byte and expect it acknowledged
  task automatic wb(input logic [7:0] v);
    logic k;
    M.wr_byte(v, k);
    chk({7'h00, k}, 8'h01);
  endtask : wb

  // ---------------------------------------------------------------
  // watchdogs
  // ---------------------------------------------------------------
  always @(negedge clk)
  begin
    cycles++;
    if (rstn && scl_oe !== 1'h0)
    begin
      fail_count++;
      $display("unexpected at %0t: clock line driven", $time);
    end
    if (cycles == 95000)
    begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      finish_test;
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    repeat (4) @(negedge clk);
    repeat (2) @(posedge link_clk);
    @(negedge clk);
    rstn = 1'h1;
    chk({2'h0, sda_o, scl_o, sda_oe, scl_oe, hs, wr_stb}, 8'h00);
    chk({7'h00, tsel}, 8'h00);
    chk(reg_addr, 8'h00);
    chk(wr_data, 8'h00);
    $display("reset done");
    foreach (rows[i])
    begin
      addr_sel = rows[i].sel;
      repeat (40) @(negedge clk);
      M.start();
      M.wr_byte({rows[i].a, 1'h0}, a);
      chk({7'h00, a}, {7'h00, rows[i].ack});
      chk({7'h00, tsel}, {7'h00, rows[i].a == ADDR_TEST});
      M.stop();
      chk({6'h00, tsel, sda_oe}, 8'h00);
    end
    $display("address table done");
    addr_sel = 1'h1;
    repeat (40) @(negedge clk);
    M.start();
    wb(8'h90);
    wb(8'hfe);
    wb(8'ha1);
    wb(8'hb2);
    wb(8'hc3);
    wb(8'hd4);
    M.stop();
    chk(mem[8'hfe], 8'ha1);
    chk(mem[8'hff], 8'hb2);
    chk(mem[8'h00], 8'hc3);
    chk(mem[8'h01], 8'hd4);
    $display("sequential write done");
    M.start();
    wb(8'h90);
    wb(8'hfe);
    M.start();
    wb(8'h91);
    M.rd_byte(1'h1, b);
    chk(b, 8'ha1);
    M.rd_byte(1'h1, b);
    chk(b, 8'hb2);
    M.rd_byte(1'h0, b);
    chk(b, 8'hc3);
    M.stop();
    M.start();
    wb(8'h91);
    M.rd_byte(1'h0, b);
    chk(b, 8'hd4);
    M.stop();
    $display("sequential read done");
    M.start();
    M.wr_byte(8'h00, a);
    chk({7'h00, a}, 8'h00);
    M.wr_byte(8'h90, a);
    chk({7'h00, a}, 8'h00);
    M.stop();
    chk(mem[8'h90], 8'h00);
    $display("general call done");
    M.start();
    M.wr_byte(8'h09, a);
    chk({7'h00, a}, 8'h00);
    chk({7'h00, hs}, 8'h01);
    M.start();
    wb(8'h90);
    wb(8'h10);
    wb(8'h5a);
    chk({7'h00, hs}, 8'h01);
    M.stop();
    chk({7'h00, hs}, 8'h00);
    chk(mem[8'h10], 8'h5a);
    $display("high speed entry done");
    // mid-run reset while the bus rests: pointer back to zero, outputs quiet
    rstn = 1'h0;
    repeat (4) @(negedge clk);
    chk({2'h0, sda_o, scl_o, sda_oe, scl_oe, hs, wr_stb}, 8'h00);
    chk({7'h00, tsel}, 8'h00);
    chk(reg_addr, 8'h00);
    repeat (2) @(posedge link_clk);
    @(negedge clk);
    rstn = 1'h1;
    repeat (40) @(negedge clk);
    chk({6'h00, sda_oe, hs}, 8'h00);
    M.start();
    wb(8'h91);
    M.rd_byte(1'h0, b);
    chk(b, 8'hc3);
    M.stop();
    chk({7'h00, sda_oe}, 8'h00);
    $display("mid-run reset done");
    finish_test;
  end
endmodule : tb_top
